// file: shared/dtc_pkg.sv
package dtc_pkg;

	// ****************************************************
	// Widths
	// ****************************************************
	localparam int DTC_CNT_W = 8;
	localparam int DTC_PRE_W = 11;
	localparam int DTC_LS_W  = 3;

	// ****************************************************
	// Control register field positions
	// ****************************************************
	localparam int DTC_CR_FLOP_BIT = 7;
	localparam int DTC_CR_RUN_BIT  = 3;
	localparam int DTC_CR_SEL_LSB  = 4;
	localparam int DTC_CR_MODE_LSB = 0;

	// ****************************************************
	// Prescaler tap exponents (high-speed source)
	// ****************************************************
	localparam int DTC_TAP_SLOW = 11;
	localparam int DTC_TAP_MID  = 7;
	localparam int DTC_TAP_FAST = 5;
	localparam int DTC_TAP_TOP  = 3;

	// ****************************************************
	// Clock select codes
	// ****************************************************
	localparam logic [2:0] DTC_SEL_SLOW  = 3'h0;
	localparam logic [2:0] DTC_SEL_MID   = 3'h1;
	localparam logic [2:0] DTC_SEL_FAST  = 3'h2;
	localparam logic [2:0] DTC_SEL_TOP   = 3'h3;
	localparam logic [2:0] DTC_SEL_EVENT = 3'h7;

	// ****************************************************
	// Operating mode codes
	// ****************************************************
	localparam logic [2:0] DTC_MODE_TIMER = 3'h0;
	localparam logic [2:0] DTC_MODE_DIV   = 3'h1;

	// ****************************************************
	// Reset values
	// ****************************************************
	localparam logic [7:0] DTC_CR_RST  = 8'h00;
	localparam logic [7:0] DTC_CMP_RST = 8'h00;
	localparam logic [7:0] DTC_CNT_RST = 8'h00;
	localparam logic       DTC_FF_RST  = 1'b0;

	// ****************************************************
	// Control register layout
	// ****************************************************
	typedef struct packed {
		logic       flop_initial_value;
		logic [2:0] clock_select_field;
		logic       run_control_bit;
		logic [2:0] operating_mode_field;
	} dtc_ctrl_t;

	// Unit state shown to software
	typedef struct packed {
		logic [7:0] count;
		logic [7:0] compare;
		logic       flop;
	} dtc_stat_t;

endpackage

// file: hw/dtc_edge.sv
`timescale 1ns/1ns
// ****************************************************
// Event input synchroniser and falling edge detector
// ****************************************************
module dtc_edge
	import dtc_pkg::*;
(
	// Clock and reset
	input  wire logic clk,
	input  wire logic sys_rst,
	input  wire logic ce,
	// Raw pin and detected edge
	input  wire logic pin_in,
	output logic      fall
);

	logic meta_ff;
	logic sync_ff;
	logic prev_ff;

	// Two-stage synchroniser, then one stage of history
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			meta_ff <= 1'b1;
			sync_ff <= 1'b1;
			prev_ff <= 1'b1;
		end else if (ce) begin
			meta_ff <= pin_in;
			sync_ff <= meta_ff;
			prev_ff <= sync_ff;
		end
	end

	// One enable per high-to-low transition
	assign fall = ce & prev_ff & ~sync_ff;

endmodule

// file: hw/dtc_top.sv
`timescale 1ns/1ns
// Behaviour
// - Timer mode counts internal ticks; match raises irq, clears, continues.
// - Event mode counts pin falls; match raises irq, clears, resumes.
// - Divider mode toggles the flop, clears counter and raises irq per match.
// - Divider output pin always shows the inverse of the flop.
// - Software loads the flop through its initial value bit; reset clears it.
// - Compare register has no shadow; new value compares immediately.
// - Stopping in divider mode holds the output level until flop rewritten.
// - Clearing bit 3 stops; clearing bit 7 then drives output high.
// - Clock select codes 000, 001, 010, 011 pick the documented prescaler taps.
// - Run bit 0 stops and clears the counter; 1 starts counting in timer and divider modes only.
module dtc_top
	import dtc_pkg::*;
#(
	parameter int UNITS = 2
)
(
	// Clock, reset, clock enable
	input  wire logic                 clk,
	input  wire logic                 sys_rst,
	input  wire logic                 ce,
	// Low-speed source tick and divider stage select
	input  wire logic                 low_speed_source,
	input  wire logic                 divider_stage_select,
	// Register writes, one strobe bit per unit
	input  wire logic [UNITS-1:0]     ctrl_wr,
	input  wire logic [7:0]           ctrl_wdata,
	input  wire logic [UNITS-1:0]     cmp_wr,
	input  wire logic [7:0]           cmp_wdata,
	// External event pins
	input  wire logic [UNITS-1:0]     event_input_pin,
	// Register and state read-back
	output dtc_ctrl_t [UNITS-1:0]     timer_control_register,
	output dtc_stat_t [UNITS-1:0]     unit_status,
	// Per-unit outputs
	output logic [UNITS-1:0]          divider_output_pin,
	output logic [UNITS-1:0]          timer_match_irq
);

	// ****************************************************
	// Elaboration checks
	// ****************************************************
	if (UNITS < 1 || UNITS > 8) begin : g_bad_units
		$error("dtc_top: UNITS must lie in 1..8");
	end

	// ****************************************************
	// Shared prescaler
	// ****************************************************
	logic [DTC_PRE_W-1:0] pre_ff;
	logic [DTC_LS_W-1:0]  ls_ff;
	logic                 tick_slow;
	logic                 tick_mid;
	logic                 tick_fast;
	logic                 tick_top;
	logic                 tick_ls8;

	// Free-running high-speed divider chain
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pre_ff <= '0;
		end else if (ce) begin
			pre_ff <= pre_ff + 1'b1;
		end
	end

	// Low-speed divide-by-eight on the sampled low-speed tick
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ls_ff <= '0;
		end else if (ce && low_speed_source) begin
			ls_ff <= ls_ff + 1'b1;
		end
	end

	// One-cycle tick when the low bits of the chain wrap
	assign tick_slow = ce & (&pre_ff[DTC_TAP_SLOW-1:0]);
	assign tick_mid  = ce & (&pre_ff[DTC_TAP_MID-1:0]);
	assign tick_fast = ce & (&pre_ff[DTC_TAP_FAST-1:0]);
	assign tick_top  = ce & (&pre_ff[DTC_TAP_TOP-1:0]);
	assign tick_ls8  = ce & low_speed_source & (&ls_ff);

	// ****************************************************
	// Timer units
	// ****************************************************
	for (genvar u = 0; u < UNITS; u++) begin : g_unit
		dtc_ctrl_t      ctrl_ff;
		logic [7:0]     cmp_ff;
		logic [7:0]     cnt_ff;
		logic           flop_ff;
		logic           pin_ff;
		logic           irq_ff;
		logic           ev_fall;
		logic           tick;
		logic           active;
		logic           hit;
		logic           nxt_flop;
		logic [7:0]     nxt_cnt;
		logic [7:0]     inc;

		dtc_edge u_edge (
			.clk     (clk),
			.sys_rst (sys_rst),
			.ce      (ce),
			.pin_in  (event_input_pin[u]),
			.fall    (ev_fall)
		);

		// Source clock selection
		always_comb begin
			case (ctrl_ff.clock_select_field)
				DTC_SEL_SLOW: begin
					tick = divider_stage_select ? tick_ls8 : tick_slow;
				end
				DTC_SEL_MID: begin
					tick = tick_mid;
				end
				DTC_SEL_FAST: begin
					tick = tick_fast;
				end
				DTC_SEL_TOP: begin
					tick = tick_top;
				end
				DTC_SEL_EVENT: begin
					tick = ev_fall;
				end
				default: begin
					tick = 1'b0;
				end
			endcase
		end

		// Only the 8-bit timer/event and divider modes count here
		assign active = ctrl_ff.run_control_bit &&
			(ctrl_ff.operating_mode_field == DTC_MODE_TIMER ||
			 ctrl_ff.operating_mode_field == DTC_MODE_DIV);
		assign inc = cnt_ff + 8'h01;
		// Live compare value, no shadow stage
		assign hit = active & tick & (inc == cmp_ff);

		// Next counter value
		always_comb begin
			if (!ctrl_ff.run_control_bit) begin
				nxt_cnt = DTC_CNT_RST;
			end else if (hit) begin
				nxt_cnt = DTC_CNT_RST;
			end else if (active && tick) begin
				nxt_cnt = inc;
			end else begin
				nxt_cnt = cnt_ff;
			end
		end

		// Next flop value: software load, else toggle on divider match
		always_comb begin
			if (ctrl_wr[u]) begin
				nxt_flop = ctrl_wdata[DTC_CR_FLOP_BIT];
			end else if (hit && ctrl_ff.operating_mode_field ==
				DTC_MODE_DIV) begin
				nxt_flop = ~flop_ff;
			end else begin
				nxt_flop = flop_ff;
			end
		end

		// Control register
		always_ff @(posedge clk) begin
			if (sys_rst) begin
				ctrl_ff <= DTC_CR_RST;
			end else if (ce && ctrl_wr[u]) begin
				ctrl_ff <= ctrl_wdata;
			end
		end

		// Compare register
		always_ff @(posedge clk) begin
			if (sys_rst) begin
				cmp_ff <= DTC_CMP_RST;
			end else if (ce && cmp_wr[u]) begin
				cmp_ff <= cmp_wdata;
			end
		end

		// Up-counter
		always_ff @(posedge clk) begin
			if (sys_rst) begin
				cnt_ff <= DTC_CNT_RST;
			end else if (ce) begin
				cnt_ff <= nxt_cnt;
			end
		end

		// Timer flop and its inverted pin image
		always_ff @(posedge clk) begin
			if (sys_rst) begin
				flop_ff <= DTC_FF_RST;
				pin_ff  <= ~DTC_FF_RST;
			end else if (ce) begin
				flop_ff <= nxt_flop;
				pin_ff  <= ~nxt_flop;
			end
		end

		// Match interrupt pulse
		always_ff @(posedge clk) begin
			if (sys_rst) begin
				irq_ff <= 1'b0;
			end else if (ce) begin
				irq_ff <= hit;
			end
		end

		assign timer_control_register[u] = ctrl_ff;
		assign unit_status[u].count      = cnt_ff;
		assign unit_status[u].compare    = cmp_ff;
		assign unit_status[u].flop       = flop_ff;
		assign divider_output_pin[u]     = pin_ff;
		assign timer_match_irq[u]        = irq_ff;
	end

endmodule

// file: verification/dtc_props.sv
`timescale 1ns/1ns
// ****************************************************
// Unit 0 port checks
// ****************************************************
module dtc_props
	import dtc_pkg::*;
#(
	parameter int UNITS = 2
)
(
	// Clock and reset
	input wire logic             clk,
	input wire logic             sys_rst,
	input wire logic             ce,
	// Register writes
	input wire logic [UNITS-1:0] ctrl_wr,
	input wire logic [7:0]       ctrl_wdata,
	input wire logic [UNITS-1:0] cmp_wr,
	input wire logic [7:0]       cmp_wdata,
	// Read-back and unit outputs
	input dtc_ctrl_t [UNITS-1:0] timer_control_register,
	input dtc_stat_t [UNITS-1:0] unit_status,
	input wire logic [UNITS-1:0] divider_output_pin,
	input wire logic [UNITS-1:0] timer_match_irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// Short views of unit 0
	wire [7:0] cnt = unit_status[0].count;
	wire [7:0] cmp = unit_status[0].compare;
	wire       flp = unit_status[0].flop;
	wire       irq = timer_match_irq[0];
	wire [2:0] mde = timer_control_register[0].operating_mode_field;
	wire       run = timer_control_register[0].run_control_bit;
	wire       dv  = mde == DTC_MODE_DIV;
	pin_inverse_a: assert property (divider_output_pin[0] == !flp)
		else $error("divider pin not inverse of flop");
	irq_clears_a: assert property (irq |-> cnt == 8'h00 ##1 !irq)
		else $error("match did not clear or pulse once");
	irq_match_a: assert property (irq |->
		8'($past(cnt) + 8'h01) == $past(cmp))
		else $error("match without equal compare");
	flop_toggle_a: assert property (irq && !$past(ctrl_wr[0]) |->
		(flp != $past(flp)) == dv)
		else $error("flop toggle wrong for mode");
	ctrl_load_a: assert property (ctrl_wr[0] && ce |=>
		flp == $past(ctrl_wdata[7]))
		else $error("flop not loaded by control write");
	// Run bit drops at the write edge, count clears one edge later
	stop_clear_a: assert property (ctrl_wr[0] && ce && !ctrl_wdata[3] |->
		##2 cnt == 8'h00)
		else $error("stop did not clear count");
	stop_hold_a: assert property (!run && !ctrl_wr[0] |=>
		$stable(divider_output_pin[0]) && cnt == 8'h00)
		else $error("stopped unit changed");
	count_step_a: assert property ($changed(cnt) |->
		cnt == 8'($past(cnt) + 8'h01) || cnt == 8'h00)
		else $error("count skipped");
	cmp_load_a: assert property (cmp_wr[0] && ce |=>
		cmp == $past(cmp_wdata))
		else $error("compare not loaded at once");
endmodule

// file: verification/testbench.sv
`timescale 1ns/1ns
module testbench;
	import dtc_pkg::*;
	// ****************************************************
	// Stimulus, watcher and verdict
	// ****************************************************
	logic            clk = 1'b0;
	logic            sys_rst = 1'b1;
	logic [1:0]      ctrl_wr = '0;
	logic [1:0]      cmp_wr = '0;
	logic [1:0]      ev = '1;
	logic [7:0]      wdata = '0;
	logic [7:0]      cdata = '0;
	logic            ce = 1'b1;
	logic            lss = 1'b0;
	logic            dss = 1'b0;
	dtc_ctrl_t [1:0] tcr;
	dtc_stat_t [1:0] st;
	logic [1:0]      pin;
	logic [1:0]      irq;
	int              num_errors = 0;
	int              n_checks = 0;
	int              gap = 0;
	int              irq1_n = 0;
	logic [16:0]     notes[$];
	dtc_top i_dut (.clk(clk), .sys_rst(sys_rst), .ce(ce),
		.low_speed_source(lss), .divider_stage_select(dss),
		.ctrl_wr(ctrl_wr), .ctrl_wdata(wdata), .cmp_wr(cmp_wr),
		.cmp_wdata(cdata), .event_input_pin(ev),
		.timer_control_register(tcr), .unit_status(st),
		.divider_output_pin(pin), .timer_match_irq(irq));
	initial begin
		forever #5 clk = ~clk;
	end
	// Low-speed tick on every second clock
	always @(posedge clk) lss <= ~lss;
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic conclude();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic wctl(input int u, input logic [7:0] d);
		ctrl_wr[u] <= 1'b1;
		wdata <= d;
		@(posedge clk);
		ctrl_wr <= '0;
	endtask
	task automatic wcmp(input int u, input logic [7:0] d);
		cmp_wr[u] <= 1'b1;
		cdata <= d;
		@(posedge clk);
		cmp_wr <= '0;
	endtask
	// Bounded wait until every noted match has been seen
	task automatic drain(input int lim);
		for (int i = 0; i < lim && notes.size() > 0; i++) @(posedge clk);
		if (notes.size() > 0) begin
			num_errors++;
			conclude();
		end
	endtask
	// Match watcher: flop level and gap since last match against notes
	always @(posedge clk) begin
		logic [16:0] nt;
		gap <= gap + 1;
		if (irq[0] === 1'b1) begin
			gap <= 1;
			nt = (notes.size() > 0) ? notes.pop_front() : 17'h1_ffff;
			check(st[0].flop, nt[16]);
			if (nt[15:0] != 16'h0000) check(gap[15:0], nt[15:0]);
		end
		if (irq[1] === 1'b1) irq1_n <= irq1_n + 1;
	end
	// Main sequence
	initial begin
		int c;
		logic [15:0] taps [5];
		taps = '{16'h0800, 16'h0080, 16'h0020, 16'h0008, 16'h0010};
		void'($urandom(32'h2eb4));
		repeat (4) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		check({pin, irq}, 16'h000c);
		for (int k = 0; k < 5; k++) begin
			wcmp(0, 8'h01);
			notes.push_back({1'b0, 16'h0000});
			notes.push_back({1'b0, taps[k]});
			dss <= (k == 4);
			wctl(0, {2'b00, k[1:0], 1'b1, 3'h0});
			drain(5000);
			wctl(0, 8'h00);
			$display("tap %0d done", k);
		end
		wcmp(0, 8'h02);
		notes.push_back({1'b1, 16'h0000});
		notes.push_back({1'b0, 16'h0010});
		notes.push_back({1'b1, 16'h0010});
		wctl(0, 8'h39);
		drain(200);
		wctl(0, 8'hb1);
		repeat (20) @(posedge clk);
		check(pin[0], 1'b0);
		check(st[0].count, 8'h00);
		// A write with the clock enable low must be ignored
		ce <= 1'b0;
		wctl(0, 8'h31);
		@(posedge clk);
		check(pin[0], 1'b0);
		ce <= 1'b1;
		wctl(0, 8'h31);
		@(posedge clk);
		check(pin[0], 1'b1);
		check(tcr[0], 16'h0031);
		$display("divider done");
		c = $urandom_range(5, 1);
		wcmp(1, c[7:0]);
		wctl(1, 8'h78);
		for (int n = 1; n <= 12; n++) begin
			ev[1] <= 1'b0;
			repeat ($urandom_range(5, 2)) @(posedge clk);
			ev[1] <= 1'b1;
			repeat ($urandom_range(5, 2)) @(posedge clk);
			check(st[1].count, 8'(n % c));
		end
		// Let the watcher count the last match pulse first
		@(posedge clk);
		check(irq1_n, 16'(12 / c));
		check(st[1].compare, c[7:0]);
		check(st[0].count, 8'h00);
		$display("event done");
		conclude();
	end
endmodule
bind dtc_top dtc_props #(.UNITS(UNITS)) i_props (.clk(clk),
	.sys_rst(sys_rst), .ce(ce), .ctrl_wr(ctrl_wr),
	.ctrl_wdata(ctrl_wdata), .cmp_wr(cmp_wr), .cmp_wdata(cmp_wdata),
	.timer_control_register(timer_control_register),
	.unit_status(unit_status), .divider_output_pin(divider_output_pin),
	.timer_match_irq(timer_match_irq));
